// ---- sgs_defs.svh ----
// register offsets, field positions, reset values and constants of the group selector
`ifndef SGS_DEFS_SVH
`define SGS_DEFS_SVH

`define SGS_CTRL_OFS 8'h00
`define SGS_OVR_OFS 8'h04
`define SGS_REM_OFS 8'h08
`define SGS_STAT_OFS 8'h0C
`define SGS_FAIL_OFS 8'h10
`define SGS_PSEL_OFS 8'h14
`define SGS_PDATA_OFS 8'h18

`define SGS_CTRL_OVR_BIT 0
`define SGS_CTRL_CNT_LSB 4
`define SGS_STAT_EN_LSB 8
`define SGS_STAT_BUSY_BIT 16

`define SGS_SEL_NONE 4'h0
`define SGS_SEL_MAX 4'h8
`define SGS_GROUPS 8
`define SGS_DEFAULT_PARAM 32'h0000_0000

`define SGS_RESP_OKAY 2'h0
`define SGS_RESP_SLVERR 2'h2

`endif

// ---- sgs_pkg.sv ----
// types shared by the group selector files
package sgs_pkg;

  typedef enum logic [0:0] {
    SGS_LD_IDLE,
    SGS_LD_LOAD
  } sgs_ld_e;

  typedef struct packed {
    logic [2:0] used_cnt;
    logic ovr_en;
  } sgs_ctrl_s;

  typedef struct packed {
    logic lower_prio;
    logic force_fail;
    logic not_cfg;
  } sgs_fail_s;

endpackage

// ---- sgs_param_mem.sv ----
// eight-word parameter store, one word per group, registered read
`timescale 1ns/1ps

module sgs_param_mem (
  // clock
  input wire logic clk_sys,
  // write port
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [31:0] wdata,
  // read port
  input wire logic [2:0] raddr,
  output logic [31:0] rdata
);

  logic [31:0] mem [0:7];

  // storage is not reset; the loader fills a group before it is used
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read data comes out of a flop, one cycle after the address
  always_ff @(posedge clk_sys) begin
    rdata <= mem[raddr];
  end

endmodule

// ---- sgs_selector.sv ----
// parameter group selector with axi4-lite registers and group parameter store
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sgs_defs.svh"

// Overview of operation
// - up to eight groups; reset enables only group one; idle with one group
// - read-only active group indication, group one after reset
// - override selector: 0 none, 1..8 select groups one to eight
// - override acts only when target enabled and override enable set
// - override enable ignores automatic control until software clears it
// - override selection latches the group like a pulse request
// - on override release, held level requests take control at once
// - count field n enables groups one through n+1
// - newly enabled groups get default parameter values loaded
// - remote selector 0 none, 1..8 groups; write acts as group request
// - with override enable clear, remote request rejected while a higher group is held by a level
// - fixed priority, group one highest; simultaneous pin requests take highest; a pin request beats a same-cycle remote write
// - request inputs are active-high bits, pulses or held levels
// - with override enable clear, a held group one request blocks every other request
// - held request on groups two to seven blocks lower groups only
// - held group eight request blocks nothing
// - pulse-activated group stays active until another group wins a request or a smaller count drops it
// - request for a disabled group flags failure, active group unchanged
module sgs_selector (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // group request pins, asynchronous
  input wire logic [7:0] grp_req_pin,
  // axi4-lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // selection result
  output logic [2:0] active_group,
  output logic [7:0] active_onehot,
  output logic req_fail
);

  // enabled mask from the count field: n enables n+1 groups
  function automatic logic [7:0] en_mask(input logic [2:0] cnt);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < `SGS_GROUPS; i++) begin
      m[i] = (i <= int'(cnt));
    end
    return m;
  endfunction

  // lowest set index wins, group one is bit zero
  function automatic logic [3:0] prio_pick(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = `SGS_GROUPS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  // levels on groups one..seven mask every lower group; group eight masks none
  function automatic logic [7:0] below_mask(input logic [7:0] lvl);
    logic [7:0] b;
    b = 8'h00;
    for (int j = 1; j < `SGS_GROUPS; j++) begin
      for (int i = 0; i < j && i < 7; i++) begin
        b[j] = b[j] | lvl[i];
      end
    end
    return b;
  endfunction

  // byte-lane merge for full-word registers
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (st[k]) begin
        r[8*k +: 8] = nw[8*k +: 8];
      end
    end
    return r;
  endfunction

  sgs_pkg::sgs_ctrl_s ctrl_reg;
  sgs_pkg::sgs_fail_s fail_reg;
  sgs_pkg::sgs_fail_s fail_set;
  sgs_pkg::sgs_ld_e ld_state_reg;
  logic [3:0] ovr_sel_reg;
  logic [3:0] rem_sel_reg;
  logic [2:0] psel_reg;
  logic [7:0] sync1_reg;
  logic [7:0] lvl_reg;
  logic [7:0] prev_reg;
  logic ovr_prev_reg;
  logic [2:0] active_reg;
  logic [2:0] active_next;
  logic [7:0] onehot_reg;
  logic fail_pulse_reg;
  logic [2:0] ld_idx_reg;
  logic [2:0] ld_end_reg;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg, rd_pend_reg;
  logic aw_held_reg, w_held_reg;
  logic [7:0] aw_addr_reg, rd_addr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] mem_rdata;
  logic aw_fire, w_fire, wr_fire, ar_fire;
  logic ctrl_wr, ovr_wr, rem_wr, fail_wr, psel_wr, pdata_wr, wr_ok;
  logic [7:0] enabled, rise, blk, cand;
  logic [3:0] auto_pick, hold_pick;
  logic resume, rem_hi_held, ld_start;
  logic [2:0] new_cnt;

  // bus handshakes; a write is performed once both halves are held
  assign aw_fire = s_axi_awvalid & awready_reg;
  assign w_fire = s_axi_wvalid & wready_reg;
  assign ar_fire = s_axi_arvalid & arready_reg;
  assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign ctrl_wr = wr_fire && aw_addr_reg == `SGS_CTRL_OFS && wstrb_reg[0];
  assign ovr_wr = wr_fire && aw_addr_reg == `SGS_OVR_OFS && wstrb_reg[0];
  assign rem_wr = wr_fire && aw_addr_reg == `SGS_REM_OFS && wstrb_reg[0];
  assign fail_wr = wr_fire && aw_addr_reg == `SGS_FAIL_OFS && wstrb_reg[0];
  assign psel_wr = wr_fire && aw_addr_reg == `SGS_PSEL_OFS && wstrb_reg[0];
  assign pdata_wr = wr_fire && aw_addr_reg == `SGS_PDATA_OFS;
  assign wr_ok = aw_addr_reg <= `SGS_PDATA_OFS && aw_addr_reg[1:0] == 2'h0
                 && aw_addr_reg != `SGS_STAT_OFS;
  assign new_cnt = wdata_reg[`SGS_CTRL_CNT_LSB +: 3];
  assign ld_start = ctrl_wr && new_cnt > ctrl_reg.used_cnt;

  // request conditioning: edges are fresh requests, levels block lower ones
  assign enabled = en_mask(ctrl_reg.used_cnt);
  assign rise = lvl_reg & ~prev_reg;
  assign resume = ovr_prev_reg & ~ctrl_reg.ovr_en;
  assign blk = below_mask(lvl_reg);
  assign cand = (rise | (resume ? lvl_reg : 8'h00)) & ~blk;
  assign auto_pick = prio_pick(cand);
  assign hold_pick = prio_pick(lvl_reg);
  assign rem_hi_held = rem_sel_next_hi(wdata_reg[3:0], lvl_reg);

  // remote target is lower than some group held by a level on groups one..seven
  function automatic logic rem_sel_next_hi(input logic [3:0] sel, input logic [7:0] lvl);
    logic h;
    h = 1'b0;
    for (int i = 0; i < 7; i++) begin
      if (int'(sel) > i + 1 && lvl[i]) begin
        h = 1'b1;
      end
    end
    return h;
  endfunction

  // pins pass two flops before any logic looks at them
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_reg <= 8'h00;
      lvl_reg <= 8'h00;
      prev_reg <= 8'h00;
    end else begin
      sync1_reg <= grp_req_pin;
      lvl_reg <= sync1_reg;
      prev_reg <= lvl_reg;
    end
  end

  // selection: override path, automatic path, then remote path
  always_comb begin
    active_next = active_reg;
    fail_set = '0;
    if (ctrl_reg.ovr_en) begin
      // automatic requests are ignored here; latest command latches
      if (ovr_wr || rem_wr) begin
        if (wdata_reg[3:0] != `SGS_SEL_NONE && wdata_reg[3:0] <= `SGS_SEL_MAX
            && enabled[3'(wdata_reg[3:0] - 4'h1)]) begin
          active_next = 3'(wdata_reg[3:0] - 4'h1);
        end else if (wdata_reg[3:0] != `SGS_SEL_NONE) begin
          fail_set.not_cfg = 1'b1;
        end
      end
    end else begin
      if (ovr_wr && wdata_reg[3:0] != `SGS_SEL_NONE) begin
        fail_set.force_fail = 1'b1;
      end
      if (auto_pick[3]) begin
        if (enabled[auto_pick[2:0]]) begin
          active_next = auto_pick[2:0];
        end else begin
          fail_set.not_cfg = 1'b1;
        end
      end else if (rem_wr && wdata_reg[3:0] != `SGS_SEL_NONE) begin
        if (rem_hi_held) begin
          fail_set.lower_prio = 1'b1;
        end else if (wdata_reg[3:0] <= `SGS_SEL_MAX
                     && enabled[3'(wdata_reg[3:0] - 4'h1)]) begin
          active_next = 3'(wdata_reg[3:0] - 4'h1);
        end else begin
          fail_set.not_cfg = 1'b1;
        end
      end
    end
    // a group dropped by a smaller count falls back to group one
    if (!enabled[active_next]) begin
      active_next = 3'h0;
    end
  end

  // active group and its decoded copies; nothing else moves it (holds after release unless a level is held)
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      active_reg <= 3'h0;
      onehot_reg <= 8'h01;
      fail_pulse_reg <= 1'b0;
      ovr_prev_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
      onehot_reg <= 8'(8'h01 << active_next);
      fail_pulse_reg <= |fail_set;
      ovr_prev_reg <= ctrl_reg.ovr_en;
    end
  end

  // software settings; override enable stays until written to zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg <= '0;
      ovr_sel_reg <= `SGS_SEL_NONE;
      rem_sel_reg <= `SGS_SEL_NONE;
      psel_reg <= 3'h0;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg.ovr_en <= wdata_reg[`SGS_CTRL_OVR_BIT];
        ctrl_reg.used_cnt <= new_cnt;
      end
      if (ovr_wr) begin
        ovr_sel_reg <= wdata_reg[3:0];
      end
      if (rem_wr) begin
        rem_sel_reg <= wdata_reg[3:0];
      end
      if (psel_wr) begin
        psel_reg <= wdata_reg[2:0];
      end
    end
  end

  // sticky failure flags, write one to clear; a new failure beats the clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fail_reg <= '0;
    end else begin
      fail_reg <= (fail_wr ? (fail_reg & ~sgs_pkg::sgs_fail_s'(wdata_reg[2:0])) : fail_reg)
                  | fail_set;
    end
  end

  // default loader; starts at reset for group one, later for newly enabled groups
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ld_state_reg <= sgs_pkg::SGS_LD_LOAD;
      ld_idx_reg <= 3'h0;
      ld_end_reg <= 3'h0;
    end else begin
      unique case (ld_state_reg)
        sgs_pkg::SGS_LD_IDLE: begin
          if (ld_start) begin
            ld_state_reg <= sgs_pkg::SGS_LD_LOAD;
            ld_idx_reg <= 3'(ctrl_reg.used_cnt + 3'h1);
            ld_end_reg <= new_cnt;
          end
        end
        sgs_pkg::SGS_LD_LOAD: begin
          if (ld_idx_reg == ld_end_reg) begin
            ld_state_reg <= sgs_pkg::SGS_LD_IDLE;
          end else begin
            ld_idx_reg <= 3'(ld_idx_reg + 3'h1);
          end
        end
      endcase
    end
  end

  // loader owns the write port while it runs; bus writes are stalled meanwhile, reads go on
  sgs_param_mem u_mem (
    .clk_sys(clk_sys),
    .we(ld_state_reg == sgs_pkg::SGS_LD_LOAD || pdata_wr),
    .waddr(ld_state_reg == sgs_pkg::SGS_LD_LOAD ? ld_idx_reg : psel_reg),
    .wdata(ld_state_reg == sgs_pkg::SGS_LD_LOAD ? `SGS_DEFAULT_PARAM
           : strb_merge(mem_rdata, wdata_reg, wstrb_reg)),
    .raddr(psel_reg),
    .rdata(mem_rdata)
  );

  // write channels: address and data captured independently, one write at a time
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `SGS_RESP_OKAY;
    end else begin
      awready_reg <= !(aw_held_reg || aw_fire) && !bvalid_reg && !wr_fire
                     && ld_state_reg == sgs_pkg::SGS_LD_IDLE;
      wready_reg <= !(w_held_reg || w_fire) && !bvalid_reg && !wr_fire
                    && ld_state_reg == sgs_pkg::SGS_LD_IDLE;
      if (aw_fire) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[7:0];
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (w_fire) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? `SGS_RESP_OKAY : `SGS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read channel: address taken, data one cycle later so the store has settled
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      arready_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `SGS_RESP_OKAY;
    end else begin
      arready_reg <= !ar_fire && !rd_pend_reg && !rvalid_reg;
      if (ar_fire) begin
        rd_pend_reg <= 1'b1;
        rd_addr_reg <= s_axi_araddr[7:0];
      end else begin
        rd_pend_reg <= 1'b0;
      end
      if (rd_pend_reg) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= `SGS_RESP_OKAY;
        unique case (rd_addr_reg)
          `SGS_CTRL_OFS: rdata_reg <= 32'({ctrl_reg.used_cnt, 3'h0, ctrl_reg.ovr_en});
          `SGS_OVR_OFS: rdata_reg <= 32'(ovr_sel_reg);
          `SGS_REM_OFS: rdata_reg <= 32'(rem_sel_reg);
          `SGS_STAT_OFS: rdata_reg <= 32'({ld_state_reg == sgs_pkg::SGS_LD_LOAD,
                                            enabled, 5'h00, active_reg});
          `SGS_FAIL_OFS: rdata_reg <= 32'(fail_reg);
          `SGS_PSEL_OFS: rdata_reg <= 32'(psel_reg);
          `SGS_PDATA_OFS: rdata_reg <= mem_rdata;
          default: begin
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `SGS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign active_group = active_reg;
  assign active_onehot = onehot_reg;
  assign req_fail = fail_pulse_reg;

  // checks on the selection behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_reset_group_one: assert property ($past(rst) |-> active_reg == 3'h0 && !ctrl_reg.ovr_en
      && rem_sel_reg == `SGS_SEL_NONE && ovr_sel_reg == `SGS_SEL_NONE)
    else $error("reset did not restore group one");
  a_single_group_idle: assert property (ctrl_reg.used_cnt == 3'h0
      && $past(ctrl_reg.used_cnt) == 3'h0 |-> active_reg == 3'h0)
    else $error("group other than one active with one group enabled");
  a_override_gated: assert property (ovr_wr && !ctrl_reg.ovr_en && wdata_reg[3:0] != 4'h0
      |=> fail_reg.force_fail ##1 fail_reg.force_fail || $past(fail_wr))
    else $error("override without enable not flagged");
  a_auto_ignored: assert property (ctrl_reg.ovr_en && !ovr_wr && !rem_wr && !ctrl_wr
      |=> $stable(active_reg))
    else $error("active group moved while override held");
  a_remote_reject: assert property (rem_wr && !ctrl_reg.ovr_en && !auto_pick[3] && rem_hi_held
      |=> $stable(active_reg) && fail_reg.lower_prio)
    else $error("remote request past a held higher group");
  a_prio_pick: assert property (!ctrl_reg.ovr_en && auto_pick[3] && enabled[auto_pick[2:0]]
      |=> active_reg == $past(auto_pick[2:0]))
    else $error("highest requester not selected");
  a_group_one_hold: assert property (!ctrl_reg.ovr_en && lvl_reg[0] && prev_reg[0]
      && active_reg == 3'h0 |=> active_reg == 3'h0)
    else $error("held group one request overridden");
  a_not_cfg_flag: assert property (!ctrl_reg.ovr_en && auto_pick[3] && !enabled[auto_pick[2:0]]
      |=> $stable(active_reg) && fail_reg.not_cfg && req_fail)
    else $error("disabled group request not refused");
  a_resume_levels: assert property (resume && hold_pick[3] && enabled[hold_pick[2:0]]
      |=> active_reg == $past(hold_pick[2:0]))
    else $error("levels did not take over on release");
  a_default_load: assert property (ld_start |=> ld_state_reg == sgs_pkg::SGS_LD_LOAD
      && ld_idx_reg == 3'($past(ctrl_reg.used_cnt) + 3'h1))
    else $error("newly enabled group not loaded");

endmodule

// ---- sgs_req_src.sv ----
// model of the relay inputs that drive the group request pins
`timescale 1ns/1ps

module sgs_req_src (
  // clock
  input wire logic clk_sys,
  // request pins toward the selector
  output logic [7:0] grp_req_pin
);
  logic [7:0] lvl_reg;
  logic [7:0] pls_reg;

  // pins idle low from time zero, well before the selector leaves reset
  initial begin
    lvl_reg = 8'h00;
    pls_reg = 8'h00;
  end

  // active-high pins; pulses and held levels share one bit per group
  assign grp_req_pin = lvl_reg | pls_reg;

  // four clocks, so the two-flop synchroniser cannot miss it
  task automatic pulse(input logic [7:0] m);
    @(posedge clk_sys);
    pls_reg <= m;
    repeat (4) @(posedge clk_sys);
    pls_reg <= 8'h00;
  endtask

  // static levels stay until replaced
  task automatic level(input logic [7:0] m);
    @(posedge clk_sys);
    lvl_reg <= m;
  endtask
endmodule

// ---- tb_top.sv ----
// self-checking bench for the group selector
`timescale 1ns/1ps
`include "sgs_defs.svh"

module tb_top;
  logic clk_sys;
  logic rst;
  logic [7:0] req_pin;
  logic [31:0] awaddr, wdata, araddr;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, req_fail;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rdv;
  logic [2:0] active_group;
  logic [7:0] active_onehot;
  int bad_count;
  int tests_run;
  int fail_seen;

  // 100 MHz
  always #5 clk_sys = ~clk_sys;

  // each one-cycle failure pulse is counted once, seen at the following edge
  always @(posedge clk_sys) begin
    if (req_fail === 1'b1) fail_seen++;
  end

  sgs_req_src u_src (.clk_sys(clk_sys), .grp_req_pin(req_pin));

  sgs_selector u_dut (
    .clk_sys(clk_sys), .rst(rst), .grp_req_pin(req_pin),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .active_group(active_group), .active_onehot(active_onehot), .req_fail(req_fail)
  );

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    awaddr <= {24'h00_0000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 200);
    resp = bresp;
    bready <= 1'b0;
    if (n >= 200) chk("write timeout", 32'h0000_0001, 32'h0000_0000);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk_sys);
    araddr <= {24'h00_0000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    rdv = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n >= 200) chk("read timeout", 32'h0000_0001, 32'h0000_0000);
  endtask

  // pin requests land three edges after the pin, so twelve is ample
  task automatic settle(input logic [2:0] g);
    repeat (12) @(posedge clk_sys);
    chk("active_group", 32'(active_group), 32'(g));
    chk("active_onehot", 32'(active_onehot), 32'h0000_0001 << g);
  endtask

  task automatic tend(input string name);
    $display("test %s done", name);
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog well beyond the thousand or so cycles the tests need
  initial begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    test_done;
  end

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    awaddr = 32'h0000_0000;
    wdata = 32'h0000_0000;
    araddr = 32'h0000_0000;
    wstrb = 4'hf;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    bad_count = 0;
    tests_run = 0;
    fail_seen = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    settle(3'd0);
    axi_rd(`SGS_STAT_OFS);
    chk("status", rdv & 32'h0000_ff07, 32'h0000_0100);
    tend("reset");
    // only group one enabled: a request elsewhere fails
    u_src.pulse(8'h04);
    settle(3'd0);
    axi_rd(`SGS_FAIL_OFS);
    chk("fail flags", rdv, 32'h0000_0001);
    chk("req_fail pulses", 32'(fail_seen), 32'h0000_0001);
    axi_wr(`SGS_FAIL_OFS, 32'h0000_0007);
    tend("disabled");
    // every count code, mask read back from status
    for (int n = 0; n < 8; n++) begin
      axi_wr(`SGS_CTRL_OFS, 32'(n) << 4);
      axi_rd(`SGS_STAT_OFS);
      chk("enabled mask", (rdv >> 8) & 32'h0000_00ff, (32'h0000_0002 << n) - 1);
    end
    // a group disabled then enabled again comes back at defaults
    axi_wr(`SGS_PSEL_OFS, 32'h0000_0005);
    axi_wr(`SGS_PDATA_OFS, 32'h1234_5678);
    axi_rd(`SGS_PDATA_OFS);
    chk("param", rdv, 32'h1234_5678);
    axi_wr(`SGS_CTRL_OFS, 32'h0000_0000);
    axi_wr(`SGS_CTRL_OFS, 32'h0000_0070);
    axi_wr(`SGS_PSEL_OFS, 32'h0000_0005);
    axi_rd(`SGS_PDATA_OFS);
    chk("param", rdv, `SGS_DEFAULT_PARAM);
    tend("count");
    // pulses latch; simultaneous pulses go to the higher group
    u_src.pulse(8'h10);
    settle(3'd4);
    u_src.pulse(8'h24);
    settle(3'd2);
    u_src.level(8'h02);
    settle(3'd1);
    u_src.pulse(8'h20);
    settle(3'd1);
    axi_wr(`SGS_REM_OFS, 32'h0000_0003);
    settle(3'd1);
    axi_rd(`SGS_FAIL_OFS);
    chk("lower prio flag", rdv & 32'h0000_0004, 32'h0000_0004);
    chk("req_fail pulses", 32'(fail_seen), 32'h0000_0002);
    u_src.pulse(8'h01);
    settle(3'd0);
    u_src.level(8'h01);
    u_src.pulse(8'h02);
    settle(3'd0);
    u_src.level(8'h80);
    settle(3'd7);
    u_src.pulse(8'h40);
    settle(3'd6);
    u_src.level(8'h00);
    tend("priority");
    // remote selector: a code requests, zero does nothing
    axi_wr(`SGS_REM_OFS, 32'h0000_0004);
    settle(3'd3);
    axi_wr(`SGS_REM_OFS, 32'h0000_0000);
    settle(3'd3);
    tend("remote");
    // override refused while its enable is clear
    axi_wr(`SGS_FAIL_OFS, 32'h0000_0007);
    axi_wr(`SGS_OVR_OFS, 32'h0000_0006);
    settle(3'd3);
    axi_rd(`SGS_FAIL_OFS);
    chk("force flag", rdv & 32'h0000_0002, 32'h0000_0002);
    chk("req_fail pulses", 32'(fail_seen), 32'h0000_0003);
    axi_wr(`SGS_CTRL_OFS, 32'h0000_0071);
    for (int g = 1; g < 9; g++) begin
      axi_wr(`SGS_OVR_OFS, 32'(g));
      settle(3'(g - 1));
    end
    // a code past group eight is refused and leaves the group alone
    axi_wr(`SGS_OVR_OFS, 32'h0000_0009);
    settle(3'd7);
    chk("req_fail pulses", 32'(fail_seen), 32'h0000_0004);
    u_src.pulse(8'h02);
    settle(3'd7);
    axi_wr(`SGS_CTRL_OFS, 32'h0000_0070);
    settle(3'd7);
    axi_wr(`SGS_CTRL_OFS, 32'h0000_0071);
    u_src.level(8'h08);
    settle(3'd7);
    axi_wr(`SGS_CTRL_OFS, 32'h0000_0070);
    settle(3'd3);
    u_src.level(8'h00);
    tend("override");
    // unmapped read and read-only write are refused
    axi_rd(8'h40);
    chk("unmapped resp", 32'(resp), 32'(`SGS_RESP_SLVERR));
    chk("unmapped data", rdv, 32'h0000_0000);
    axi_wr(`SGS_STAT_OFS, 32'h0000_0005);
    chk("status write resp", 32'(resp), 32'(`SGS_RESP_SLVERR));
    settle(3'd3);
    // a control write without its low byte lane changes nothing
    wstrb <= 4'h0;
    axi_wr(`SGS_CTRL_OFS, 32'h0000_0001);
    wstrb <= 4'hf;
    chk("masked write resp", 32'(resp), 32'(`SGS_RESP_OKAY));
    axi_rd(`SGS_CTRL_OFS);
    chk("masked write", rdv, 32'h0000_0070);
    tend("bus");
    // mid-run reset drops override, selectors and flags
    axi_wr(`SGS_CTRL_OFS, 32'h0000_0071);
    axi_wr(`SGS_REM_OFS, 32'h0000_0002);
    settle(3'd1);
    axi_wr(`SGS_OVR_OFS, 32'h0000_0005);
    settle(3'd4);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    settle(3'd0);
    axi_rd(`SGS_CTRL_OFS);
    chk("ctrl after reset", rdv, 32'h0000_0000);
    axi_rd(`SGS_OVR_OFS);
    chk("override sel after reset", rdv, 32'h0000_0000);
    axi_rd(`SGS_REM_OFS);
    chk("remote sel after reset", rdv, 32'h0000_0000);
    axi_rd(`SGS_FAIL_OFS);
    chk("fail after reset", rdv, 32'h0000_0000);
    axi_rd(`SGS_STAT_OFS);
    chk("status after reset", rdv, 32'h0000_0100);
    chk("read resp", 32'(resp), 32'(`SGS_RESP_OKAY));
    tend("reset again");
    test_done;
  end
endmodule
